// ---- pkg/tls_pkg.sv ----
/*
 Shared constants, state type and timing figures for the tape load sequencer.
 Assumes a single 100 MHz system clock.
*/
package tls_pkg;
   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int LOAD_TMR_MS = 670;
   localparam int LOAD_TMR_CYC = LOAD_TMR_MS * (CLK_HZ / 1000);
   localparam int TACH_SLOW_US = 61;
   localparam int TACH_MID_US = 56;
   localparam int TACH_FAST_US = 47;
   localparam int TACH_SLOW_CYC = TACH_SLOW_US * (CLK_HZ / 1_000_000);
   localparam int TACH_MID_CYC = TACH_MID_US * (CLK_HZ / 1_000_000);
   localparam int TACH_FAST_CYC = TACH_FAST_US * (CLK_HZ / 1_000_000);
   localparam int TACH_TOL_PCT = 4;
   localparam int PCT_FULL = 100;

   // ----------------------------------------------------------------
   // Widths and field values
   // ----------------------------------------------------------------
   localparam int TMR_W = 27;
   localparam int TACH_W = 14;
   localparam int GAP_W = 3;
   localparam int SYNC_W = 13;
   localparam logic [GAP_W-1:0] GAP_ZERO = 3'h0;
   localparam logic [GAP_W-1:0] GAP_ONE = 3'h1;
   localparam logic [GAP_W-1:0] GAP_MAX = 3'h7;
   localparam logic [GAP_W-1:0] GAP_END_CNT = 3'h4;
   localparam logic [1:0] MODEL_SLOW = 2'h0;
   localparam logic [1:0] MODEL_MID = 2'h1;
   localparam logic [TACH_W-1:0] TACH_ONE = 14'h0001;
   localparam logic [TACH_W-1:0] TACH_ZERO = 14'h0000;

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_THREAD,
      ST_REVERSE,
      ST_WAIT_TMR,
      ST_COLUMNS,
      ST_DONE
   } tls_state_t;
endpackage

// ---- pkg/tls_tmr_if.sv ----
/*
 Interface between the sequencer and its load single-shot timer.
 Assumes both ends run on the one system clock.
*/
`timescale 1ns/1ns
interface tls_tmr_if;
   logic start;
   logic cancel;
   logic busy;
   logic expired;
   modport owner (output start, output cancel, input busy, input expired);
   modport timer (input start, input cancel, output busy, output expired);
endinterface

// ---- src/tls_sync.sv ----
/*
 Two-stage synchroniser for a group of pin inputs.
 Assumes inputs are asynchronous levels; only the second stage is read outside.
*/
`timescale 1ns/1ns
module tls_sync #(
   parameter int W = tls_pkg::SYNC_W
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   import tls_pkg::*;

   // ----------------------------------------------------------------
   // One synchroniser per bit
   // ----------------------------------------------------------------
   for (genvar g = 0; g < W; g++) begin : g_bit
      logic meta_ff;
      logic sync_ff;
      always_ff @(posedge i_clk) begin
         if (i_sys_rst) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
         end else begin
            meta_ff <= i_async[g];
            sync_ff <= meta_ff;
         end
      end
      assign o_sync[g] = sync_ff;
   end
endmodule

// ---- src/tls_load_timer.sv ----
/*
 Single-shot load timer: a start while idle runs it once for CYC cycles.
 Assumes start and cancel come from logic on the same clock.
*/
`timescale 1ns/1ns
module tls_load_timer #(
   parameter int CYC = tls_pkg::LOAD_TMR_CYC
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   tls_tmr_if.timer tmr
);
   import tls_pkg::*;

   localparam logic [TMR_W-1:0] LOAD_VAL = TMR_W'(CYC - 1);
   localparam logic [TMR_W-1:0] CNT_ZERO = '0;

   logic [TMR_W-1:0] cnt_ff;
   logic busy_ff;
   logic expired_ff;
   logic fire;
   logic done;

   // ----------------------------------------------------------------
   // Countdown
   // ----------------------------------------------------------------
   // Retrigger while running is ignored: this is a single shot
   assign fire = tmr.start && !busy_ff;
   assign done = busy_ff && (cnt_ff == CNT_ZERO);

   always_ff @(posedge i_clk) begin
      if (i_sys_rst || tmr.cancel) begin
         cnt_ff <= CNT_ZERO;
         busy_ff <= 1'b0;
         expired_ff <= 1'b0;
      end else if (fire) begin
         cnt_ff <= LOAD_VAL;
         busy_ff <= 1'b1;
         expired_ff <= 1'b0;
      end else if (done) begin
         busy_ff <= 1'b0;
         expired_ff <= 1'b1;
      end else if (busy_ff) begin
         cnt_ff <= cnt_ff - 1'b1;
      end
   end

   assign tmr.busy = busy_ff;
   assign tmr.expired = expired_ff;
endmodule

// ---- src/tls_sequencer.sv ----
/*
 Automatic tape load sequencer: threading, gap counting, left reel reversal,
 load timer, column loading and the rewind-to-load-point request, plus a
 capstan tachometer period monitor.
 Assumes all sensor inputs are asynchronous switch or photocell levels and
 that the reel, valve and capstan drivers act on the registered commands.
*/
`timescale 1ns/1ns
module tls_sequencer #(
   parameter int P_LOAD_TMR_CYC = tls_pkg::LOAD_TMR_CYC,
   parameter int P_TACH_SLOW_CYC = tls_pkg::TACH_SLOW_CYC,
   parameter int P_TACH_MID_CYC = tls_pkg::TACH_MID_CYC,
   parameter int P_TACH_FAST_CYC = tls_pkg::TACH_FAST_CYC
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_load_req,
   input wire logic i_tape_start_marker,
   input wire logic i_gap_pulse,
   input wire logic i_reels_loaded_sw,
   input wire logic i_air_bearing_press_sw,
   input wire logic i_left_reel_ccw_fb,
   input wire logic i_left_lower_vac_switch,
   input wire logic i_right_lower_vac_switch,
   input wire logic i_left_upper_vac_switch,
   input wire logic i_right_upper_vac_switch,
   input wire logic i_tach_pulse,
   input wire logic [1:0] i_model_sel,
   output logic o_load_in_progress,
   output logic o_thread,
   output logic o_transfer_valve,
   output logic o_left_reel_cw,
   output logic o_left_reel_ccw,
   output logic o_right_reel_half,
   output logic o_reversal,
   output logic o_column_control,
   output logic o_columns_loaded,
   output logic o_load_complete,
   output logic o_motion_cmd,
   output logic o_load_check,
   output logic o_tach_fault
);
   import tls_pkg::*;

   // ----------------------------------------------------------------
   // Tach limits
   // ----------------------------------------------------------------
   localparam int TOL_LO = PCT_FULL - TACH_TOL_PCT;
   localparam int TOL_HI = PCT_FULL + TACH_TOL_PCT;
   localparam logic [TACH_W-1:0] SLOW_MIN = TACH_W'((P_TACH_SLOW_CYC * TOL_LO + PCT_FULL - 1) / PCT_FULL);
   localparam logic [TACH_W-1:0] SLOW_MAX = TACH_W'((P_TACH_SLOW_CYC * TOL_HI) / PCT_FULL);
   localparam logic [TACH_W-1:0] MID_MIN = TACH_W'((P_TACH_MID_CYC * TOL_LO + PCT_FULL - 1) / PCT_FULL);
   localparam logic [TACH_W-1:0] MID_MAX = TACH_W'((P_TACH_MID_CYC * TOL_HI) / PCT_FULL);
   localparam logic [TACH_W-1:0] FAST_MIN = TACH_W'((P_TACH_FAST_CYC * TOL_LO + PCT_FULL - 1) / PCT_FULL);
   localparam logic [TACH_W-1:0] FAST_MAX = TACH_W'((P_TACH_FAST_CYC * TOL_HI) / PCT_FULL);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [SYNC_W-1:0] sync_q;
   logic s_load, s_marker, s_gap, s_reels, s_press, s_ccw_fb;
   logic s_ll, s_rl, s_lu, s_ru, s_tach;
   logic [1:0] s_model;

   tls_sync #(.W(SYNC_W)) u_sync (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_async({i_model_sel, i_tach_pulse, i_right_upper_vac_switch, i_left_upper_vac_switch,
                i_right_lower_vac_switch, i_left_lower_vac_switch, i_left_reel_ccw_fb,
                i_air_bearing_press_sw, i_reels_loaded_sw, i_gap_pulse, i_tape_start_marker, i_load_req}),
      .o_sync(sync_q)
   );
   assign {s_model, s_tach, s_ru, s_lu, s_rl, s_ll, s_ccw_fb, s_press, s_reels, s_gap, s_marker, s_load} = sync_q;

   // ----------------------------------------------------------------
   // Edge detection
   // ----------------------------------------------------------------
   logic load_prev_ff, marker_prev_ff, gap_prev_ff, reels_prev_ff, tach_prev_ff;
   logic load_rise, marker_rise, gap_rise, reels_rise, tach_rise;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         {load_prev_ff, marker_prev_ff, gap_prev_ff, reels_prev_ff, tach_prev_ff} <= '0;
      end else begin
         {load_prev_ff, marker_prev_ff, gap_prev_ff, reels_prev_ff, tach_prev_ff} <=
            {s_load, s_marker, s_gap, s_reels, s_tach};
      end
   end

   assign load_rise = s_load && !load_prev_ff;
   assign marker_rise = s_marker && !marker_prev_ff;
   assign gap_rise = s_gap && !gap_prev_ff;
   assign reels_rise = s_reels && !reels_prev_ff;
   assign tach_rise = s_tach && !tach_prev_ff;

   // ----------------------------------------------------------------
   // Load timer
   // ----------------------------------------------------------------
   tls_tmr_if tmr ();

   tls_load_timer #(.CYC(P_LOAD_TMR_CYC)) u_tmr (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .tmr(tmr.timer)
   );

   // ----------------------------------------------------------------
   // Sequencer state and decode
   // ----------------------------------------------------------------
   tls_state_t state_ff, nxt_state;
   logic [GAP_W-1:0] gap_cnt_ff, nxt_gap_cnt;
   logic marker_seen_ff, nxt_marker_seen;
   logic lip_ff, thread_ff, valve_ff, lcw_ff, lccw_ff, rhalf_ff, rev_ff;
   logic colctl_ff, colld_ff, done_ff, motion_ff, check_ff;
   logic nxt_lip, nxt_thread, nxt_valve, nxt_lcw, nxt_lccw, nxt_rhalf, nxt_rev;
   logic nxt_colctl, nxt_colld, nxt_done, nxt_motion, nxt_check;
   logic gap_clear, gap_end, bad_marker, bad_reels, press_go, rev_go, vac_ok;

   assign gap_clear = marker_rise && s_reels && thread_ff;
   assign gap_end = thread_ff && marker_seen_ff && (gap_cnt_ff == GAP_END_CNT);
   assign bad_marker = marker_rise && !s_reels && (state_ff == ST_THREAD);
   assign bad_reels = reels_rise && lip_ff && !thread_ff;
   assign press_go = !thread_ff && s_press && lcw_ff;
   assign rev_go = lip_ff && lccw_ff && s_ccw_fb;
   assign vac_ok = s_ll && s_rl && !s_lu && !s_ru;
   assign tmr.start = (state_ff == ST_REVERSE) && rev_go;
   assign tmr.cancel = bad_reels;

   always_comb begin
      nxt_state = state_ff;
      nxt_gap_cnt = gap_cnt_ff;
      nxt_marker_seen = marker_seen_ff;
      {nxt_lip, nxt_thread, nxt_valve, nxt_lcw, nxt_lccw, nxt_rhalf} =
         {lip_ff, thread_ff, valve_ff, lcw_ff, lccw_ff, rhalf_ff};
      {nxt_rev, nxt_colctl, nxt_colld, nxt_done, nxt_motion, nxt_check} =
         {rev_ff, colctl_ff, colld_ff, done_ff, motion_ff, check_ff};
      case (state_ff)
         ST_IDLE: begin
            if (load_rise && !check_ff) begin
               nxt_state = ST_THREAD;
               {nxt_lip, nxt_thread, nxt_valve} = 3'h7;
               {nxt_lcw, nxt_rhalf} = 2'h3;
               nxt_gap_cnt = GAP_ZERO;
               nxt_marker_seen = 1'b0;
            end
         end
         ST_THREAD: begin
            if (bad_marker) begin
               nxt_state = ST_IDLE;
               {nxt_lip, nxt_thread, nxt_valve, nxt_lcw, nxt_rhalf} = '0;
            end else if (gap_end) begin
               nxt_state = ST_REVERSE;
               {nxt_thread, nxt_valve, nxt_rhalf} = '0;
            end else if (gap_clear) begin
               nxt_gap_cnt = GAP_ZERO;
               nxt_marker_seen = 1'b1;
            end else if (gap_rise && gap_cnt_ff != GAP_MAX) begin
               nxt_gap_cnt = gap_cnt_ff + GAP_ONE;
            end
         end
         ST_REVERSE: begin
            if (press_go) begin
               nxt_lcw = 1'b0;
               nxt_lccw = 1'b1;
            end else if (rev_go) begin
               nxt_rev = 1'b1;
               nxt_state = ST_WAIT_TMR;
            end
         end
         ST_WAIT_TMR: begin
            if (tmr.expired) begin
               nxt_colctl = 1'b1;
               nxt_lccw = 1'b0;
               nxt_state = ST_COLUMNS;
            end
         end
         ST_COLUMNS: begin
            if (vac_ok) begin
               {nxt_colld, nxt_done} = 2'h3;
               nxt_lip = 1'b0;
               nxt_motion = 1'b1;
               nxt_state = ST_DONE;
            end
         end
         ST_DONE: begin
            nxt_state = ST_DONE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      if (bad_reels) begin
         nxt_state = ST_IDLE;
         {nxt_lip, nxt_lcw, nxt_lccw, nxt_rev, nxt_colctl} = '0;
      end
      if (bad_marker || bad_reels) begin
         nxt_check = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_ff <= ST_IDLE;
         gap_cnt_ff <= GAP_ZERO;
         marker_seen_ff <= 1'b0;
         {lip_ff, thread_ff, valve_ff, lcw_ff, lccw_ff, rhalf_ff} <= '0;
         {rev_ff, colctl_ff, colld_ff, done_ff, motion_ff, check_ff} <= '0;
      end else begin
         state_ff <= nxt_state;
         gap_cnt_ff <= nxt_gap_cnt;
         marker_seen_ff <= nxt_marker_seen;
         {lip_ff, thread_ff, valve_ff, lcw_ff, lccw_ff, rhalf_ff} <=
            {nxt_lip, nxt_thread, nxt_valve, nxt_lcw, nxt_lccw, nxt_rhalf};
         {rev_ff, colctl_ff, colld_ff, done_ff, motion_ff, check_ff} <=
            {nxt_rev, nxt_colctl, nxt_colld, nxt_done, nxt_motion, nxt_check};
      end
   end

   // ----------------------------------------------------------------
   // Capstan tach period monitor
   // ----------------------------------------------------------------
   logic [TACH_W-1:0] per_cnt_ff, tach_min, tach_max;
   logic tach_valid_ff, tach_fault_ff, per_bad, overrun;

   assign tach_min = (s_model == MODEL_SLOW) ? SLOW_MIN : (s_model == MODEL_MID) ? MID_MIN : FAST_MIN;
   assign tach_max = (s_model == MODEL_SLOW) ? SLOW_MAX : (s_model == MODEL_MID) ? MID_MAX : FAST_MAX;
   assign per_bad = (per_cnt_ff < tach_min) || (per_cnt_ff > tach_max);
   assign overrun = tach_valid_ff && (per_cnt_ff > tach_max);

   always_ff @(posedge i_clk) begin
      if (i_sys_rst || !motion_ff) begin
         per_cnt_ff <= TACH_ZERO;
         tach_valid_ff <= 1'b0;
         tach_fault_ff <= 1'b0;
      end else if (tach_rise) begin
         per_cnt_ff <= TACH_ONE;
         tach_valid_ff <= 1'b1;
         tach_fault_ff <= tach_valid_ff && per_bad;
      end else begin
         if (!overrun) begin
            per_cnt_ff <= per_cnt_ff + TACH_ONE;
         end
         if (overrun) begin
            tach_fault_ff <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_load_in_progress = lip_ff;
   assign o_thread = thread_ff;
   assign o_transfer_valve = valve_ff;
   assign o_left_reel_cw = lcw_ff;
   assign o_left_reel_ccw = lccw_ff;
   assign o_right_reel_half = rhalf_ff;
   assign o_reversal = rev_ff;
   assign o_column_control = colctl_ff;
   assign o_columns_loaded = colld_ff;
   assign o_load_complete = done_ff;
   assign o_motion_cmd = motion_ff;
   assign o_load_check = check_ff;
   assign o_tach_fault = tach_fault_ff;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   property p_thread_reels;
      thread_ff |-> lcw_ff && rhalf_ff;
   endproperty
   a_thread_reels: assert property (p_thread_reels) else $error("reels stopped while threading");

   property p_thread_hold;
      thread_ff && !marker_seen_ff && !marker_rise |=> thread_ff;
   endproperty
   a_thread_hold: assert property (p_thread_hold) else $error("threading ended before marker");

   property p_gap_clear;
      gap_clear && !bad_marker && !gap_end |=> gap_cnt_ff == GAP_ZERO && marker_seen_ff;
   endproperty
   a_gap_clear: assert property (p_gap_clear) else $error("gap counter not cleared at marker");

   property p_gap_end;
      gap_end && !bad_marker |=> !thread_ff && !valve_ff && state_ff == ST_REVERSE;
   endproperty
   a_gap_end: assert property (p_gap_end) else $error("threading not ended at count four");

   property p_reverse;
      state_ff == ST_REVERSE && press_go && !bad_reels |=> lccw_ff && !lcw_ff;
   endproperty
   a_reverse: assert property (p_reverse) else $error("left reel not reversed");

   property p_reversal;
      state_ff == ST_REVERSE && !press_go && rev_go && !bad_reels |=> rev_ff ##1 tmr.busy;
   endproperty
   a_reversal: assert property (p_reversal) else $error("reversal flag or timer missing");

   property p_colctl;
      $rose(colctl_ff) |-> $past(tmr.expired) && !$past(tmr.busy);
   endproperty
   a_colctl: assert property (p_colctl) else $error("column control before timer expiry");

   property p_loaded;
      state_ff == ST_COLUMNS && vac_ok && !bad_reels |=> colld_ff && done_ff;
   endproperty
   a_loaded: assert property (p_loaded) else $error("columns loaded not flagged");

   property p_motion;
      $rose(done_ff) |-> motion_ff && !lip_ff;
   endproperty
   a_motion: assert property (p_motion) else $error("motion or load flag wrong at complete");

   property p_lip;
      done_ff |-> !lip_ff;
   endproperty
   a_lip: assert property (p_lip) else $error("load in progress with load complete");

   property p_reset;
      @(posedge i_clk) $fell(i_sys_rst) |-> !thread_ff && !rev_ff && !done_ff && !colld_ff && !tmr.busy
         && gap_cnt_ff == GAP_ZERO;
   endproperty
   a_reset: assert property (p_reset) else $error("reset left state behind");

   property p_check;
      bad_marker |=> check_ff ##1 state_ff == ST_IDLE;
   endproperty
   a_check: assert property (p_check) else $error("load check not raised");

   property p_tach;
      motion_ff && tach_rise && tach_valid_ff && per_bad |=> tach_fault_ff;
   endproperty
   a_tach: assert property (p_tach) else $error("tach period fault missed");

   c_full_load: cover property ($rose(done_ff));
   c_load_check: cover property ($rose(check_ff));
   c_timer_run: cover property ($rose(tmr.expired));
   c_tach_fault: cover property ($rose(tach_fault_ff));
endmodule

// ---- tb/tls_drive_model.sv ----
/*
 Behavioural model of the tape drive around the load sequencer: pressure,
 reels-loaded and vacuum switches and the left reel direction feedback.
 Assumes the sequencer's actuator outputs as inputs; every response lags by LAG clocks.
*/
`timescale 1ns/1ns
module tls_drive_model #(
   parameter int LAG = 5
) (
   input wire logic i_clk,
   input wire logic i_load_in_progress,
   input wire logic i_transfer_valve,
   input wire logic i_right_reel_half,
   input wire logic i_left_reel_ccw,
   input wire logic i_column_control,
   input wire logic i_no_tension,
   input wire logic i_upper_bad,
   input wire logic i_stray_reels,
   output logic o_press_sw,
   output logic o_reels_sw,
   output logic o_ccw_fb,
   output logic o_lower_vac,
   output logic o_upper_vac
);
   // ----------------------------------------------------------------
   // Delayed mechanical responses
   // ----------------------------------------------------------------
   logic [LAG-1:0] sh_press_ff = '0;
   logic [LAG-1:0] sh_reels_ff = '0;
   logic [LAG-1:0] sh_ccw_ff = '0;
   logic [LAG-1:0] sh_col_ff = '0;

   always_ff @(posedge i_clk) begin
      sh_press_ff <= {sh_press_ff[LAG-2:0], i_load_in_progress & ~i_transfer_valve};
      sh_reels_ff <= {sh_reels_ff[LAG-2:0], i_right_reel_half};
      sh_ccw_ff <= {sh_ccw_ff[LAG-2:0], i_left_reel_ccw};
      sh_col_ff <= {sh_col_ff[LAG-2:0], i_column_control};
   end

   assign o_press_sw = sh_press_ff[LAG-1];
   // Stray input models a reels switch flicker after threading has ended
   assign o_reels_sw = (sh_reels_ff[LAG-1] & ~i_no_tension) | i_stray_reels;
   assign o_ccw_fb = sh_ccw_ff[LAG-1];
   // Tape drawn in sits above the lower switches; too much slack also covers the upper ones
   assign o_lower_vac = sh_col_ff[LAG-1];
   assign o_upper_vac = sh_col_ff[LAG-1] & i_upper_bad;
endmodule

// ---- tb/testbench.sv ----
/*
 Self-checking testbench for the tape load sequencer.
 Assumes the drive model on the far side; load timer and tach periods shortened.
*/
`timescale 1ns/1ns
module testbench;
   import tls_pkg::*;
   localparam int TMR = 20;

   // ----------------------------------------------------------------
   // Stimulus and observation
   // ----------------------------------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] pls = 4'h0;
   logic [1:0] model_sel = 2'h0;
   logic tach = 1'b0;
   int tach_per = 100;
   logic no_tension = 1'b0;
   logic upper_bad = 1'b1;
   logic press, reels, ccw_fb, lower_vac, upper_vac;
   logic lip, thr, valve, lcw, lccw, rhalf, rev, colc, cload, lcomp, motion, lchk, tfault;
   wire logic [12:0] obs = {lip, thr, valve, lcw, lccw, rhalf, rev, colc, cload, lcomp, motion, lchk, tfault};
   int error_cnt = 0;
   int tests_run = 0;

   always #5 clk = ~clk;

   always begin
      repeat (tach_per - 3) @(posedge clk);
      tach <= 1'b1;
      repeat (3) @(posedge clk);
      tach <= 1'b0;
   end

   tls_sequencer #(.P_LOAD_TMR_CYC(TMR), .P_TACH_SLOW_CYC(100), .P_TACH_MID_CYC(90),
      .P_TACH_FAST_CYC(80)) tls_sequencer_i (
      .i_clk(clk), .i_sys_rst(rst), .i_load_req(pls[0]), .i_tape_start_marker(pls[1]),
      .i_gap_pulse(pls[2]), .i_reels_loaded_sw(reels), .i_air_bearing_press_sw(press),
      .i_left_reel_ccw_fb(ccw_fb), .i_left_lower_vac_switch(lower_vac),
      .i_right_lower_vac_switch(lower_vac), .i_left_upper_vac_switch(upper_vac),
      .i_right_upper_vac_switch(upper_vac), .i_tach_pulse(tach), .i_model_sel(model_sel),
      .o_load_in_progress(lip), .o_thread(thr), .o_transfer_valve(valve), .o_left_reel_cw(lcw),
      .o_left_reel_ccw(lccw), .o_right_reel_half(rhalf), .o_reversal(rev), .o_column_control(colc),
      .o_columns_loaded(cload), .o_load_complete(lcomp), .o_motion_cmd(motion),
      .o_load_check(lchk), .o_tach_fault(tfault));

   tls_drive_model #(.LAG(5)) tls_drive_model_i (
      .i_clk(clk), .i_load_in_progress(lip), .i_transfer_valve(valve), .i_right_reel_half(rhalf),
      .i_left_reel_ccw(lccw), .i_column_control(colc), .i_no_tension(no_tension),
      .i_upper_bad(upper_bad), .i_stray_reels(pls[3]), .o_press_sw(press), .o_reels_sw(reels), .o_ccw_fb(ccw_fb),
      .o_lower_vac(lower_vac), .o_upper_vac(upper_vac));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic conclude();
      if (error_cnt == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input logic [12:0] got, input logic [12:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Samples at the falling edge so flop updates have landed
   task automatic wait_bit(input int b, input logic v);
      int n;
      n = 0;
      while (obs[b] !== v && n < 300) begin
         @(negedge clk);
         n++;
      end
      if (obs[b] !== v) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, obs, v);
         conclude();
      end
   endtask

   task automatic pulse(input int b);
      @(posedge clk);
      pls[b] <= 1'b1;
      repeat (3) @(posedge clk);
      pls[b] <= 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (7) @(negedge clk);
      check(obs, 13'h0000);
      @(posedge clk);
      rst <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic normal_load();
      pulse(0);
      check(obs, 13'h1E80);
      repeat (5) pulse(2);
      check(obs, 13'h1E80);
      pulse(1);
      repeat (3) pulse(2);
      check(obs, 13'h1E80);
      pulse(2);
      check(obs, 13'h1200);
      wait_bit(8, 1'b1);
      check(obs, 13'h1100);
      wait_bit(6, 1'b1);
      check(obs, 13'h1140);
      repeat (TMR - 2) @(negedge clk);
      check(obs, 13'h1140);
      wait_bit(5, 1'b1);
      check(obs, 13'h1060);
      repeat (30) @(negedge clk);
      check(obs, 13'h1060);
      @(posedge clk);
      upper_bad <= 1'b0;
      wait_bit(3, 1'b1);
      check(obs, 13'h007C);
   endtask

   task automatic tach_models();
      int per [3];
      per = '{100, 90, 80};
      for (int m = 0; m < 3; m++) begin
         @(posedge clk);
         model_sel <= 2'(m);
         tach_per <= per[m];
         repeat (500) @(negedge clk);
         check({12'h000, tfault}, 13'h0000);
         @(posedge clk);
         tach_per <= per[m] + 10;
         repeat (500) @(negedge clk);
         check({12'h000, tfault}, 13'h0001);
      end
   endtask

   task automatic marker_without_reels();
      @(posedge clk);
      no_tension <= 1'b1;
      tach_per <= 100;
      pulse(0);
      repeat (2) pulse(2);
      pulse(1);
      wait_bit(1, 1'b1);
      check(obs, 13'h0002);
   endtask

   task automatic reels_out_of_order();
      @(posedge clk);
      no_tension <= 1'b0;
      pulse(0);
      pulse(2);
      pulse(1);
      repeat (4) pulse(2);
      wait_bit(6, 1'b1);
      pulse(3);
      wait_bit(1, 1'b1);
      check(obs, 13'h0002);
   endtask

   initial begin
      do_reset();
      normal_load();
      tach_models();
      do_reset();
      marker_without_reels();
      do_reset();
      reels_out_of_order();
      do_reset();
      conclude();
   end
endmodule
